// file: verilog/dtec_top.sv
// Operation
// R1: clear-and-start clears on match, raises irq
// R2: interrupt period is compare plus one
// R3: three-bit clock select picks count clock
// R4: run bit starts and stops counting
// R5: event mode counts selected external edges
// R6: inversion toggles output on each match
// R7: force bits drive output high or low
// R8: pwm select bit chooses pwm mode
// R9: compare sets active width, polarity selectable
// R10: output enable gates the output pin
// R11: pwm stays inactive until first overflow
// R12: active from overflow until compare match
// R13: stopping pwm forces inactive level
// R14: chain bit joins units into 16 bits
// R15: chained count clock from unit a
// R16: software sets b run before a
// R17: chained full match clears both, irq a
// R18: unit b irq still fires when chained
// R19: chained run controlled by unit a
// R20: start may err by one count clock
// R21: low compare runs to overflow first
// R22: count read pauses the count clock
// R23: run low clears counter, stops prescaler
// R24: force bits read back as zero
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "dtec_consts.svh"

module dtec_top
(
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire dtec_pkg::dtec_addr_t wb_adr_i,
    input  wire dtec_pkg::dtec_word_t wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output var  dtec_pkg::dtec_word_t wb_dat_o,
    output var  logic                 wb_ack_o,
    // external event inputs
    input  wire logic                 unit_a_event_input,
    input  wire logic                 unit_b_event_input,
    // waveform outputs
    output var  logic                 unit_a_wave_output,
    output var  logic                 unit_b_wave_output,
    // match interrupt requests
    output var  logic                 unit_a_match_irq,
    output var  logic                 unit_b_match_irq
);
    import dtec_pkg::*;

    dtec_byte_t mode_r   [2];
    dtec_byte_t mode_nxt [2];
    dtec_csel_t csel_r   [2];
    dtec_csel_t csel_nxt [2];
    dtec_byte_t cmp_r    [2];
    dtec_byte_t cmp_nxt  [2];
    dtec_byte_t cnt_r    [2];
    dtec_byte_t cnt_nxt  [2];
    dtec_pwm_t  st_r     [2];
    dtec_pwm_t  st_nxt   [2];
    logic [1:0] lvl_r;
    logic [1:0] lvl_nxt;
    logic [1:0] wave_r;
    logic [1:0] wave_nxt;
    logic [1:0] irq_r;
    logic [1:0] irq_nxt;
    logic       ack_r;
    logic       ack_nxt;
    dtec_word_t dat_r;
    dtec_word_t dat_nxt;
    logic [1:0] run;
    logic [1:0] en;
    logic [1:0] pwm;
    logic [1:0] tk;
    logic [1:0] hit;
    logic [1:0] ovf;
    logic [1:0] mt;
    logic [1:0] wr_mode;
    logic [1:0] rd_cnt;
    logic       chain;
    logic       full;
    logic       req;
    logic       wr_en;

    dtec_tick_if tif_a ();
    dtec_tick_if tif_b ();

    // address of a unit's copy of a register
    function automatic dtec_addr_t uoff(input dtec_addr_t base,
                                       input int u);
        uoff = (u == 0) ? base : base + `DTEC_OFF_STEP;
    endfunction : uoff

    dtec_tick_gen u_tick_a
    (
        .clock (clock),
        .rst_b (rst_b),
        .tif   (tif_a.gen)
    );

    dtec_tick_gen u_tick_b
    (
        .clock (clock),
        .rst_b (rst_b),
        .tif   (tif_b.gen)
    );

    // bus request decode
    assign req   = wb_cyc_i & wb_stb_i;
    assign wr_en = req & wb_we_i & ack_r & wb_sel_i[0];
    assign wr_mode[0] = wr_en & (wb_adr_i == uoff(`DTEC_OFF_MODE, 0));
    assign wr_mode[1] = wr_en & (wb_adr_i == uoff(`DTEC_OFF_MODE, 1));
    assign rd_cnt[0] = req & ~wb_we_i & ~ack_r
                       & (wb_adr_i == uoff(`DTEC_OFF_CNT, 0));
    assign rd_cnt[1] = req & ~wb_we_i & ~ack_r
                       & (wb_adr_i == uoff(`DTEC_OFF_CNT, 1));

    // run and chain control
    assign chain  = mode_r[1][`DTEC_CHAIN_BIT]; // R14
    assign run[0] = mode_r[0][`DTEC_RUN_BIT]; // R4
    assign run[1] = mode_r[1][`DTEC_RUN_BIT]; // R4
    assign en[0]  = run[0];
    assign en[1]  = chain ? (run[0] & run[1]) : run[1]; // R19

    // count clock sources
    assign tif_a.csel     = csel_r[0];
    assign tif_a.run      = run[0];
    assign tif_a.pause    = rd_cnt[0] | (chain & rd_cnt[1]); // R22
    assign tif_a.event_in = unit_a_event_input;
    assign tif_b.csel     = csel_r[1];
    assign tif_b.run      = run[1] & ~chain; // R15
    assign tif_b.pause    = rd_cnt[1]; // R22
    assign tif_b.event_in = unit_b_event_input;

    // match, overflow and tick decode
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            hit[u] = cnt_r[u] == cmp_r[u];
            ovf[u] = cnt_r[u] == `DTEC_CNT_MAX;
            pwm[u] = mode_r[u][`DTEC_PWM_BIT] & ~chain; // R8
        end
        tk[0] = tif_a.tick & en[0];
        tk[1] = en[1] & (chain ? (tif_a.tick & ovf[0]) : tif_b.tick); // R15
        full  = chain & en[0] & en[1] & tif_a.tick
                & hit[0] & hit[1]; // R17
        mt[0] = chain ? full : (tk[0] & hit[0] & ~pwm[0]); // R1
        mt[1] = chain ? 1'b0 : (tk[1] & hit[1] & ~pwm[1]); // R1
    end

    // counters
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            if (!en[u])
            begin
                cnt_nxt[u] = `DTEC_CNT_RST; // R23
            end
            else if (full)
            begin
                cnt_nxt[u] = `DTEC_CNT_RST; // R17
            end
            else if (!tk[u])
            begin
                cnt_nxt[u] = cnt_r[u];
            end
            else if (mt[u])
            begin
                cnt_nxt[u] = `DTEC_CNT_RST; // R2
            end
            else
            begin
                cnt_nxt[u] = cnt_r[u] + 8'h01; // R21
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_r[0] <= `DTEC_CNT_RST;
            cnt_r[1] <= `DTEC_CNT_RST;
        end
        else
        begin
            cnt_r[0] <= cnt_nxt[0];
            cnt_r[1] <= cnt_nxt[1];
        end
    end

    // pwm phase
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            if (!en[u] || !pwm[u])
            begin
                st_nxt[u] = DTEC_PWM_WAIT; // R13
            end
            else
            begin
                case (st_r[u])
                    DTEC_PWM_WAIT:
                    begin
                        st_nxt[u] = (tk[u] && ovf[u]) ? DTEC_PWM_ACT
                                                      : DTEC_PWM_WAIT; // R11
                    end
                    DTEC_PWM_ACT, DTEC_PWM_INACT:
                    begin
                        if (tk[u] && ovf[u])
                        begin
                            st_nxt[u] = DTEC_PWM_ACT; // R12
                        end
                        else if (tk[u] && hit[u])
                        begin
                            st_nxt[u] = DTEC_PWM_INACT; // R9
                        end
                        else
                        begin
                            st_nxt[u] = st_r[u];
                        end
                    end
                    default:
                    begin
                        st_nxt[u] = DTEC_PWM_WAIT;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r[0] <= DTEC_PWM_WAIT;
            st_r[1] <= DTEC_PWM_WAIT;
        end
        else
        begin
            st_r[0] <= st_nxt[0];
            st_r[1] <= st_nxt[1];
        end
    end

    // output level, pin and interrupt requests
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            if (wr_mode[u] && wb_dat_i[`DTEC_FHI_BIT]
                && !wb_dat_i[`DTEC_FLO_BIT])
            begin
                lvl_nxt[u] = 1'b1; // R7
            end
            else if (wr_mode[u] && !wb_dat_i[`DTEC_FHI_BIT]
                     && wb_dat_i[`DTEC_FLO_BIT])
            begin
                lvl_nxt[u] = 1'b0; // R7
            end
            else if (mt[u] && mode_r[u][`DTEC_POL_BIT])
            begin
                lvl_nxt[u] = ~lvl_r[u]; // R6
            end
            else
            begin
                lvl_nxt[u] = lvl_r[u];
            end
            if (!mode_r[u][`DTEC_OE_BIT])
            begin
                wave_nxt[u] = 1'b0; // R10
            end
            else if (pwm[u])
            begin
                wave_nxt[u] = (st_nxt[u] == DTEC_PWM_ACT)
                              ^ mode_r[u][`DTEC_POL_BIT]; // R9
            end
            else
            begin
                wave_nxt[u] = lvl_nxt[u];
            end
        end
        irq_nxt[0] = mt[0]; // R1
        irq_nxt[1] = chain ? (full | (tk[1] & hit[1])) : mt[1]; // R18
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lvl_r  <= 2'h0;
            wave_r <= 2'h0;
            irq_r  <= 2'h0;
        end
        else
        begin
            lvl_r  <= lvl_nxt;
            wave_r <= wave_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // register writes
    always_comb
    begin
        for (int u = 0; u < 2; u++)
        begin
            mode_nxt[u] = mode_r[u];
            csel_nxt[u] = csel_r[u];
            cmp_nxt[u]  = cmp_r[u];
            if (wr_mode[u])
            begin
                mode_nxt[u] = wb_dat_i[7:0] & ((u == 0) ? `DTEC_WMASK_A
                                                        : `DTEC_WMASK_B); // R24
            end
            if (wr_en && wb_adr_i == uoff(`DTEC_OFF_CSEL, u))
            begin
                csel_nxt[u] = wb_dat_i[2:0]; // R3
            end
            if (wr_en && wb_adr_i == uoff(`DTEC_OFF_CMP, u))
            begin
                cmp_nxt[u] = wb_dat_i[7:0]; // R21
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_r[0] <= `DTEC_MODE_RST;
            mode_r[1] <= `DTEC_MODE_RST;
            csel_r[0] <= `DTEC_CSEL_RST;
            csel_r[1] <= `DTEC_CSEL_RST;
            cmp_r[0]  <= `DTEC_CMP_RST;
            cmp_r[1]  <= `DTEC_CMP_RST;
        end
        else
        begin
            mode_r[0] <= mode_nxt[0];
            mode_r[1] <= mode_nxt[1];
            csel_r[0] <= csel_nxt[0];
            csel_r[1] <= csel_nxt[1];
            cmp_r[0]  <= cmp_nxt[0];
            cmp_r[1]  <= cmp_nxt[1];
        end
    end

    // bus answer and read data
    always_comb
    begin
        ack_nxt = req & ~ack_r;
        dat_nxt = 32'h0000_0000;
        if (ack_nxt && !wb_we_i)
        begin
            for (int u = 0; u < 2; u++)
            begin
                if (wb_adr_i == uoff(`DTEC_OFF_MODE, u))
                begin
                    dat_nxt = {24'h00_0000, mode_r[u]}; // R24
                end
                if (wb_adr_i == uoff(`DTEC_OFF_CSEL, u))
                begin
                    dat_nxt = {29'h0000_0000, csel_r[u]};
                end
                if (wb_adr_i == uoff(`DTEC_OFF_CMP, u))
                begin
                    dat_nxt = {24'h00_0000, cmp_r[u]};
                end
                if (wb_adr_i == uoff(`DTEC_OFF_CNT, u))
                begin
                    dat_nxt = {24'h00_0000, cnt_r[u]}; // R22
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o           = ack_r;
    assign wb_dat_o           = dat_r;
    assign unit_a_wave_output = wave_r[0];
    assign unit_b_wave_output = wave_r[1];
    assign unit_a_match_irq   = irq_r[0];
    assign unit_b_match_irq   = irq_r[1];

endmodule : dtec_top

`default_nettype wire

// file: verilog/dtec_consts.svh
`ifndef DTEC_CONSTS_SVH
`define DTEC_CONSTS_SVH

// register offsets, unit b sits one step above unit a
`define DTEC_OFF_MODE    8'h00
`define DTEC_OFF_CSEL    8'h08
`define DTEC_OFF_CMP     8'h10
`define DTEC_OFF_CNT     8'h18
`define DTEC_OFF_STEP    8'h04

// mode control fields
`define DTEC_RUN_BIT     7
`define DTEC_PWM_BIT     6
`define DTEC_CHAIN_BIT   4
`define DTEC_FHI_BIT     3
`define DTEC_FLO_BIT     2
`define DTEC_POL_BIT     1
`define DTEC_OE_BIT      0
`define DTEC_WMASK_A     8'hC3
`define DTEC_WMASK_B     8'hD3

// reset values and counter maximum
`define DTEC_MODE_RST    8'h00
`define DTEC_CSEL_RST    3'h0
`define DTEC_CMP_RST     8'h00
`define DTEC_CNT_RST     8'h00
`define DTEC_CNT_MAX     8'hFF

// clock select codes
`define DTEC_CSEL_FALL   3'h0
`define DTEC_CSEL_RISE   3'h1
`define DTEC_CSEL_DIV4   3'h2
`define DTEC_CSEL_DIV8   3'h3
`define DTEC_CSEL_DIV16  3'h4
`define DTEC_CSEL_DIV32  3'h5
`define DTEC_CSEL_DIV128 3'h6
`define DTEC_CSEL_DIV512 3'h7

// prescaler width and terminal masks
`define DTEC_PRE_W       9
`define DTEC_MASK_DIV4   9'h003
`define DTEC_MASK_DIV8   9'h007
`define DTEC_MASK_DIV16  9'h00F
`define DTEC_MASK_DIV32  9'h01F
`define DTEC_MASK_DIV128 9'h07F
`define DTEC_MASK_DIV512 9'h1FF

`endif

// file: verilog/dtec_pkg.sv
`default_nettype none

package dtec_pkg;
    typedef logic [7:0]  dtec_byte_t;
    typedef logic [7:0]  dtec_addr_t;
    typedef logic [31:0] dtec_word_t;
    typedef logic [2:0]  dtec_csel_t;
    typedef enum logic [2:0]
    {
        DTEC_PWM_WAIT  = 3'h1,
        DTEC_PWM_ACT   = 3'h2,
        DTEC_PWM_INACT = 3'h4
    } dtec_pwm_t;
endpackage : dtec_pkg

`default_nettype wire

// file: verilog/dtec_tick_if.sv
`timescale 1ns/100ps
`default_nettype none

interface dtec_tick_if;
    dtec_pkg::dtec_csel_t csel;
    logic                 run;
    logic                 pause;
    logic                 event_in;
    logic                 tick;
    modport ctrl (output csel, run, pause, event_in, input tick);
    modport gen  (input csel, run, pause, event_in, output tick);
endinterface : dtec_tick_if

`default_nettype wire

// file: verilog/dtec_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtec_consts.svh"

module dtec_tick_gen
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst_b,
    // count clock control
    dtec_tick_if.gen    tif
);
    import dtec_pkg::*;

    logic [`DTEC_PRE_W-1:0] pre_r;
    logic [`DTEC_PRE_W-1:0] pre_nxt;
    logic                   prev_r;
    logic                   prev_nxt;
    logic                   pend_r;
    logic                   pend_nxt;
    logic                   tick_r;
    logic                   tick_nxt;
    logic                   raw;

    function automatic logic [`DTEC_PRE_W-1:0] div_mask(input dtec_csel_t s);
        case (s)
            `DTEC_CSEL_DIV4:   div_mask = `DTEC_MASK_DIV4;
            `DTEC_CSEL_DIV8:   div_mask = `DTEC_MASK_DIV8;
            `DTEC_CSEL_DIV16:  div_mask = `DTEC_MASK_DIV16;
            `DTEC_CSEL_DIV32:  div_mask = `DTEC_MASK_DIV32;
            `DTEC_CSEL_DIV128: div_mask = `DTEC_MASK_DIV128;
            `DTEC_CSEL_DIV512: div_mask = `DTEC_MASK_DIV512;
            default:           div_mask = `DTEC_MASK_DIV512;
        endcase
    endfunction : div_mask

    // prescaler, edge select and read pause
    always_comb
    begin
        pre_nxt  = tif.run ? pre_r + 9'h001 : 9'h000; // R20 R23
        prev_nxt = tif.event_in;
        case (tif.csel) // R3
            `DTEC_CSEL_FALL: raw = prev_r & ~tif.event_in; // R5
            `DTEC_CSEL_RISE: raw = ~prev_r & tif.event_in; // R5
            default:
                raw = (pre_r & div_mask(tif.csel)) == div_mask(tif.csel);
        endcase
        if (!tif.run)
        begin
            pend_nxt = 1'b0;
            tick_nxt = 1'b0;
        end
        else if (tif.pause)
        begin
            pend_nxt = pend_r | raw; // R22
            tick_nxt = 1'b0;
        end
        else
        begin
            pend_nxt = 1'b0;
            tick_nxt = pend_r | raw;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_r  <= 9'h000;
            prev_r <= 1'b0;
            pend_r <= 1'b0;
            tick_r <= 1'b0;
        end
        else
        begin
            pre_r  <= pre_nxt;
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tif.tick = tick_r;

endmodule : dtec_tick_gen

`default_nettype wire

// file: dv/dtec_checker.sv
`timescale 1ns/100ps
`default_nettype none

module dtec_checker
(
    // clock and reset
    input wire logic                 clock,
    input wire logic                 rst_b,
    // register bus
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire dtec_pkg::dtec_addr_t wb_adr_i,
    input wire dtec_pkg::dtec_word_t wb_dat_i,
    input wire logic [3:0]           wb_sel_i,
    input wire dtec_pkg::dtec_word_t wb_dat_o,
    input wire logic                 wb_ack_o,
    // pins and requests
    input wire logic                 unit_a_event_input,
    input wire logic                 unit_b_event_input,
    input wire logic                 unit_a_wave_output,
    input wire logic                 unit_b_wave_output,
    input wire logic                 unit_a_match_irq,
    input wire logic                 unit_b_match_irq
);
    import dtec_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    force_rd_zero_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[7:3] == 5'h00 |-> wb_dat_o[3:2] == 2'h0)
        else $error("force bits read back nonzero");
    force_high_a: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00
        && wb_dat_i[3:0] == 4'h9 |-> ##[1:2] unit_a_wave_output)
        else $error("force high not seen on output");
    force_low_a: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00
        && wb_dat_i[3:0] == 4'h5 |-> ##[1:2] !unit_a_wave_output)
        else $error("force low not seen on output");
    irq_a_pulse_a: assert property (unit_a_match_irq |=> !unit_a_match_irq)
        else $error("unit a request longer than one cycle");
    irq_b_pulse_a: assert property (unit_b_match_irq |=> !unit_b_match_irq)
        else $error("unit b request longer than one cycle");
endmodule : dtec_checker

`default_nettype wire

// file: dv/dtec_pins_model.sv
`timescale 1ns/100ps
`default_nettype none

module dtec_pins_model
(
    // clock
    input  wire logic clock,
    // event pins toward the block
    output var  logic unit_a_event_input,
    output var  logic unit_b_event_input,
    // wave pins from the block
    input  wire logic unit_a_wave_output,
    input  wire logic unit_b_wave_output
);
    int edges_a = 0;
    int edges_b = 0;

    initial
    begin
        unit_a_event_input = 1'b0;
        unit_b_event_input = 1'b0;
    end

    // edges seen on the wave pins
    always @(unit_a_wave_output) edges_a++;
    always @(unit_b_wave_output) edges_b++;

    // one level change, held long enough
    task drive_event(input int u, input logic v);
        if (u == 0)
            unit_a_event_input <= v;
        else
            unit_b_event_input <= v;
        repeat (4) @(posedge clock);
    endtask : drive_event
endmodule : dtec_pins_model

`default_nettype wire

// file: dv/tb_dtec_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_dtec_top;
    import dtec_pkg::*;
    logic       clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic       ev_a, ev_b, wave_a, wave_b, irq_a, irq_b;
    logic [3:0] wb_sel_i;
    dtec_addr_t wb_adr_i;
    dtec_word_t wb_dat_i, wb_dat_o, rd;
    int         n_errors = 0;
    int         comparisons = 0;
    int         c, u, k, p;
    int         div_tab[8] = '{0, 0, 4, 8, 16, 32, 128, 512};
    dtec_csel_t cs_tab[8] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h2};
    dtec_byte_t n_tab[8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
                             8'h00, 8'hFF};

    dtec_top u_dut (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .unit_a_event_input(ev_a),
        .unit_b_event_input(ev_b), .unit_a_wave_output(wave_a),
        .unit_b_wave_output(wave_b), .unit_a_match_irq(irq_a),
        .unit_b_match_irq(irq_b));
    dtec_pins_model u_pins (.clock(clock), .unit_a_event_input(ev_a),
        .unit_b_event_input(ev_b), .unit_a_wave_output(wave_a),
        .unit_b_wave_output(wave_b));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task wrap_up;
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    task check(input dtec_word_t seen, input dtec_word_t exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function dtec_addr_t ra(input dtec_addr_t b, input int un);
        return b + dtec_addr_t'(un * 4);
    endfunction : ra

    task bus(input dtec_addr_t a, input logic we, input dtec_byte_t d);
        int t;
        t = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        @(posedge clock);
        while (wb_ack_o !== 1'b1 && t < 50)
        begin
            t++;
            @(posedge clock);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clock);
    endtask : bus

    task rd_chk(input dtec_addr_t a, input dtec_byte_t e);
        bus(a, 1'b0, 8'h00);
        check(rd, {24'h0, e});
    endtask : rd_chk

    // cycles until the selected request or wave change
    task wait_ev(input int s, output int cy);
        logic l0;
        logic h;
        l0 = (s == 2) ? wave_a : wave_b;
        cy = 0;
        h = 1'b0;
        while (!h && cy < 3000)
        begin
            @(posedge clock);
            cy++;
            case (s)
                0: h = (irq_a === 1'b1);
                1: h = (irq_b === 1'b1);
                2: h = (wave_a !== l0);
                default: h = (wave_b !== l0);
            endcase
        end
    endtask : wait_ev

    initial
    begin
        repeat (60000) @(posedge clock);
        n_errors++;
        wrap_up();
    end

    initial
    begin
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h1;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        for (k = 0; k < 8; k++) rd_chk(ra(8'h00, k), 8'h00);
        rd_chk(8'h20, 8'h00);
        bus(8'h24, 1'b1, 8'hFF);
        bus(8'h00, 1'b1, 8'h09);
        rd_chk(8'h00, 8'h01);
        check(dtec_word_t'(wave_a), 32'h1);
        bus(8'h00, 1'b1, 8'h05);
        rd_chk(8'h00, 8'h01);
        check(dtec_word_t'(wave_a), 32'h0);
        bus(8'h04, 1'b1, 8'h1B);
        rd_chk(8'h04, 8'h13);
        check(dtec_word_t'(wave_b), 32'h1);
        bus(8'h04, 1'b1, 8'h05);
        wb_sel_i <= 4'h2;
        bus(8'h10, 1'b1, 8'h55);
        wb_sel_i <= 4'h1;
        rd_chk(8'h10, 8'h00);
        // interval timer, every prescaler code and compare edges
        for (u = 0; u < 2; u++)
            for (k = 0; k < 8; k++)
            begin
                bus(ra(8'h08, u), 1'b1, {5'h0, cs_tab[k]});
                bus(ra(8'h10, u), 1'b1, n_tab[k]);
                bus(ra(8'h00, u), 1'b1, 8'h80);
                wait_ev(u, c);
                wait_ev(u, c);
                check(c, (n_tab[k] + 1) * div_tab[cs_tab[k]]);
                bus(ra(8'h00, u), 1'b1, 8'h00);
                rd_chk(ra(8'h18, u), 8'h00);
            end
        // event counting on either edge
        for (u = 0; u < 2; u++)
            for (k = 0; k < 2; k++)
            begin
                bus(ra(8'h08, u), 1'b1, 8'(k));
                bus(ra(8'h10, u), 1'b1, 8'hFF);
                bus(ra(8'h00, u), 1'b1, 8'h80);
                u_pins.drive_event(u, 1'b1);
                rd_chk(ra(8'h18, u), 8'(k));
                u_pins.drive_event(u, 1'b0);
                rd_chk(ra(8'h18, u), 8'h01);
                bus(ra(8'h00, u), 1'b1, 8'h00);
            end
        // square wave, then output disabled
        bus(8'h08, 1'b1, 8'h02);
        bus(8'h10, 1'b1, 8'h01);
        bus(8'h00, 1'b1, 8'h83);
        wait_ev(2, c);
        wait_ev(2, c);
        check(c, 8);
        bus(8'h00, 1'b1, 8'h82);
        wait_ev(0, c);
        check(dtec_word_t'(wave_a), 32'h0);
        bus(8'h00, 1'b1, 8'h00);
        // pwm on unit b, both polarities
        for (p = 0; p < 2; p++)
        begin
            bus(8'h0C, 1'b1, 8'h02);
            bus(8'h14, 1'b1, 8'h03);
            bus(8'h04, 1'b1, 8'hC1 | 8'(p << 1));
            rd_chk(8'h04, 8'hC1 | 8'(p << 1));
            repeat (100) @(posedge clock);
            check(dtec_word_t'(wave_b), p);
            wait_ev(3, c);
            wait_ev(3, c);
            check(c, 16);
            wait_ev(3, c);
            check(c, 1008);
            bus(8'h04, 1'b1, 8'h41 | 8'(p << 1));
            rd_chk(8'h1C, 8'h00);
            check(dtec_word_t'(wave_b), p);
            bus(8'h04, 1'b1, 8'h00);
        end
        // chained 16-bit interval, unit b clock select ignored
        bus(8'h08, 1'b1, 8'h02);
        bus(8'h0C, 1'b1, 8'h07);
        bus(8'h10, 1'b1, 8'h01);
        bus(8'h14, 1'b1, 8'h01);
        bus(8'h04, 1'b1, 8'h90);
        bus(8'h00, 1'b1, 8'h80);
        wait_ev(0, c);
        wait_ev(0, c);
        check(c, 1032);
        wait_ev(1, c);
        check(c, 1032);
        bus(8'h00, 1'b1, 8'h00);
        rd_chk(8'h18, 8'h00);
        bus(8'h04, 1'b1, 8'h00);
        wrap_up();
    end
endmodule : tb_dtec_top

bind dtec_top dtec_checker u_chk (.clock(clock), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .unit_a_event_input(unit_a_event_input),
    .unit_b_event_input(unit_b_event_input),
    .unit_a_wave_output(unit_a_wave_output),
    .unit_b_wave_output(unit_b_wave_output),
    .unit_a_match_irq(unit_a_match_irq),
    .unit_b_match_irq(unit_b_match_irq));

`default_nettype wire
